// ===== hdl/status_led_top.sv
// Status indicator driver for the fieldbus slave interface.
// Assumes all inputs come from logic on mclk_i except serial activity,
// which is synchronised here.
//
// Operation
// - System indicator steady green while the fieldbus system runs.
// - System indicator alternates red and green awaiting firmware.
// - System indicator steady red while bootloader awaits second stage.
// - Error indicator blinks 2.5 Hz on invalid configuration.
// - Error indicator single flash on local error.
// - Host watchdog expiry counts as local error.
// - Sync error forces SAFE-OPERATIONAL and counts as local error.
// - Error indicator double flash on application watchdog; dark otherwise.
// - Run indicator: blink preop, single safeop, on op, off init.
// - Serial indicator flashes yellow during Modbus traffic, else off.
// - Alarm indicator blinks red while any alarm is active.
// - Hardware failure lights alarm steady red, overriding blink.
// - Multi-byte fieldbus values use little-endian byte order.
// - Alarm word reports each active alarm as its own bit.
`timescale 1ns/10ps
`default_nettype none
module status_led_top (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // System boot state
  input wire logic [2:0] sys_state_i,
  input wire logic power_good_i,
  // Fieldbus state and error causes
  input wire logic [3:0] fb_state_i,
  input wire logic cfg_invalid_i,
  input wire logic local_change_i,
  input wire logic host_wdog_i,
  input wire logic sync_err_i,
  input wire logic app_wdog_i,
  input wire logic err_clear_i,
  // Serial activity, asynchronous
  input wire logic serial_act_i,
  // Alarms
  input wire logic [15:0] alarm_bits_i,
  input wire logic hw_fail_i,
  // Indicators
  output logic system_green_o,
  output logic system_red_o,
  output logic err_led_o,
  output logic run_led_o,
  output logic serial_led_o,
  output logic power_indicator_o,
  output logic alarm_indicator_o,
  // Fieldbus side
  output logic force_safeop_o,
  output logic [7:0] alarm_byte0_o,
  output logic [7:0] alarm_byte1_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pattern sources

  logic blink;
  logic single_fl;
  logic double_fl;

  blink_gen u_blink (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .blink_o(blink)
  );

  flash_gen u_flash (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .double_i(1'b1),
    .single_o(single_fl),
    .double_o(double_fl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial activity synchroniser and stretch

  logic act_s1;
  logic act_s2;
  logic act_s3;
  logic [31:0] act_cnt;
  logic [31:0] next_act_cnt;
  logic act_edge;

  assign act_edge = act_s2 ^ act_s3;

  // Each edge restarts the stretch so a burst stays lit throughout
  always_comb begin
    next_act_cnt = act_cnt;
    if (act_edge) begin
      next_act_cnt = led_pkg::ACT_CYC;
    end else if (act_cnt != 32'h0000_0000) begin
      next_act_cnt = act_cnt - 32'h0000_0001;
    end
  end

  // Two stages before logic; the third only delays for edge detection
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
      act_s3 <= 1'b0;
    end else if (ce_i) begin
      act_s1 <= serial_act_i;
      act_s2 <= act_s1;
      act_s3 <= act_s2;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      act_cnt <= next_act_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error class latch

  // Sticky local and watchdog errors: cause wins over clear
  logic local_err;
  logic next_local_err;
  logic app_err;
  logic next_app_err;
  logic local_cause;

  assign local_cause = local_change_i || host_wdog_i || sync_err_i;

  always_comb begin
    next_local_err = local_err;
    next_app_err = app_err;
    if (err_clear_i) begin
      next_local_err = 1'b0;
      next_app_err = 1'b0;
    end
    if (local_cause) begin
      next_local_err = 1'b1;
    end
    if (app_wdog_i) begin
      next_app_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicator decode

  logic next_sys_green;
  logic next_sys_red;
  logic next_err;
  logic next_run;
  logic next_serial;
  logic next_alarm;
  logic next_force_safeop;
  logic any_alarm;

  assign any_alarm = |alarm_bits_i;

  always_comb begin
    next_sys_green = 1'b0;
    next_sys_red = 1'b0;
    if (power_good_i && !hw_fail_i) begin
      case (sys_state_i)
        led_pkg::SYS_RUN: begin
          next_sys_green = 1'b1;
        end
        led_pkg::SYS_WAIT_FW: begin
          next_sys_green = blink;
          next_sys_red = ~blink;
        end
        led_pkg::SYS_BOOT: begin
          next_sys_red = 1'b1;
        end
        default: begin
          next_sys_red = 1'b0;
        end
      endcase
    end
  end

  // Configuration error outranks the latched classes
  always_comb begin
    if (cfg_invalid_i) begin
      next_err = blink;
    end else if (next_app_err) begin
      next_err = double_fl;
    end else if (next_local_err) begin
      next_err = single_fl;
    end else begin
      next_err = 1'b0;
    end
  end

  always_comb begin
    next_force_safeop = sync_err_i ||
      (force_safeop_o && !err_clear_i);
    case (fb_state_i)
      led_pkg::FB_INIT: begin
        next_run = 1'b0;
      end
      led_pkg::FB_PREOP: begin
        next_run = blink;
      end
      led_pkg::FB_SAFEOP: begin
        next_run = single_fl;
      end
      led_pkg::FB_OP: begin
        next_run = 1'b1;
      end
      default: begin
        next_run = 1'b0;
      end
    endcase
    if (next_force_safeop) begin
      next_run = single_fl;
    end
  end

  always_comb begin
    // No blink gate: a short burst could fall wholly in a dark half
    next_serial = (act_cnt != 32'h0000_0000);
    if (hw_fail_i) begin
      next_alarm = 1'b1;
    end else if (any_alarm) begin
      next_alarm = blink;
    end else begin
      next_alarm = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers

  // Sticky error classes; only err_clear_i brings them back down
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      local_err <= 1'b0;
      app_err <= 1'b0;
    end else if (ce_i) begin
      local_err <= next_local_err;
      app_err <= next_app_err;
    end
  end

  // Request toward the fieldbus state machine, held until cleared
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      force_safeop_o <= 1'b0;
    end else if (ce_i) begin
      force_safeop_o <= next_force_safeop;
    end
  end

  // Indicators are registered so the pins never glitch on decode
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      system_green_o <= 1'b0;
      system_red_o <= 1'b0;
      err_led_o <= 1'b0;
      run_led_o <= 1'b0;
      serial_led_o <= 1'b0;
      power_indicator_o <= 1'b0;
      alarm_indicator_o <= 1'b0;
    end else if (ce_i) begin
      system_green_o <= next_sys_green;
      system_red_o <= next_sys_red;
      err_led_o <= next_err;
      run_led_o <= next_run;
      serial_led_o <= next_serial;
      power_indicator_o <= power_good_i;
      alarm_indicator_o <= next_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm word toward the fieldbus

  // Little-endian: lane 0 carries bits 7:0 and goes out first
  logic [7:0] alarm_lane [2];

  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    assign alarm_lane[lane] = alarm_bits_i[8*lane +: 8];
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_byte0_o <= led_pkg::ALARM_RST[7:0];
      alarm_byte1_o <= led_pkg::ALARM_RST[15:8];
    end else if (ce_i) begin
      alarm_byte0_o <= alarm_lane[0];
      alarm_byte1_o <= alarm_lane[1];
    end
  end

endmodule : status_led_top
`default_nettype wire

// ===== hdl/led_pkg.sv
// Package: constants and types for the status indicator driver.
// Assumes a 20 MHz system clock.
package led_pkg;

  // Clock
  localparam int unsigned CLK_HZ = 20_000_000;

  // Blink rate 2.5 Hz: half period in cycles
  localparam int unsigned BLINK_MHZ = 2500;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (BLINK_MHZ * 2 / 1000);

  // Flash pattern timing in milliseconds
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_GAP_MS = 200;
  localparam int unsigned FLASH_OFF_MS = 1000;
  localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int unsigned FLASH_GAP_CYC = CLK_HZ / 1000 * FLASH_GAP_MS;
  localparam int unsigned FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;

  // Serial activity flash length
  localparam int unsigned ACT_MS = 50;
  localparam int unsigned ACT_CYC = CLK_HZ / 1000 * ACT_MS;

  // Alarm word
  localparam int unsigned ALARM_W = 16;
  localparam logic [15:0] ALARM_RST = 16'h0000;

  // Fieldbus states
  typedef enum logic [3:0] {
    FB_INIT = 4'b0001,
    FB_PREOP = 4'b0010,
    FB_SAFEOP = 4'b0100,
    FB_OP = 4'b1000
  } fb_state_t;

  // System boot states
  typedef enum logic [2:0] {
    SYS_BOOT = 3'b001,
    SYS_WAIT_FW = 3'b010,
    SYS_RUN = 3'b100
  } sys_state_t;

  // Flash sequencer states
  typedef enum logic [4:0] {
    FL_ON1 = 5'b00001,
    FL_GAP = 5'b00010,
    FL_ON2 = 5'b00100,
    FL_OFF = 5'b01000,
    FL_IDLE = 5'b10000
  } flash_state_t;

endpackage : led_pkg

// ===== hdl/flash_gen.sv
// Flash pattern generator: single or double flash, repeating.
// Assumes counts from led_pkg and a synchronous enable.
`timescale 1ns/10ps
`default_nettype none
module flash_gen (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control
  input wire logic double_i,
  // Pattern
  output logic single_o,
  output logic double_o
);

  led_pkg::flash_state_t state;
  led_pkg::flash_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 32'h0000_0001;
    case (state)
      led_pkg::FL_ON1: begin
        if (cnt >= led_pkg::FLASH_ON_CYC - 1) begin
          next_cnt = 32'h0000_0000;
          next_state = led_pkg::FL_GAP;
        end
      end
      led_pkg::FL_GAP: begin
        if (cnt >= led_pkg::FLASH_GAP_CYC - 1) begin
          next_cnt = 32'h0000_0000;
          next_state = led_pkg::FL_ON2;
        end
      end
      led_pkg::FL_ON2: begin
        if (cnt >= led_pkg::FLASH_ON_CYC - 1) begin
          next_cnt = 32'h0000_0000;
          next_state = led_pkg::FL_OFF;
        end
      end
      led_pkg::FL_OFF: begin
        if (cnt >= led_pkg::FLASH_OFF_CYC - 1) begin
          next_cnt = 32'h0000_0000;
          next_state = led_pkg::FL_ON1;
        end
      end
      default: begin
        next_cnt = 32'h0000_0000;
        next_state = led_pkg::FL_ON1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= led_pkg::FL_IDLE;
      cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Long off gap separates repeats
  assign single_o = (state == led_pkg::FL_ON1);
  assign double_o = (state == led_pkg::FL_ON1) ||
    (double_i && (state == led_pkg::FL_ON2));

endmodule : flash_gen
`default_nettype wire

// ===== hdl/blink_gen.sv
// Square wave generator at the 2.5 Hz blink rate.
// Assumes counts from led_pkg and a synchronous enable.
`timescale 1ns/10ps
`default_nettype none
module blink_gen (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Square wave
  output logic blink_o
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic phase;
  logic next_phase;

  always_comb begin
    next_cnt = cnt + 32'h0000_0001;
    next_phase = phase;
    if (cnt >= led_pkg::BLINK_HALF_CYC - 1) begin
      next_cnt = 32'h0000_0000;
      next_phase = ~phase;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 32'h0000_0000;
      phase <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end

  assign blink_o = phase;

endmodule : blink_gen
`default_nettype wire

// ===== test/led_observer.sv
// Operator model: counts how often one indicator lights up.
// Assumes the indicator is a registered level on mclk_i.
`timescale 1ns/10ps
`default_nettype none
module led_observer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Indicator
  input wire logic led_i,
  output logic [7:0] edges_o
);
  logic last;
  // Saturates so a long run never wraps to zero
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last <= 1'b0;
      edges_o <= 8'h00;
    end else begin
      last <= led_i;
      if (led_i && !last && edges_o != 8'hff) edges_o <= edges_o + 8'h01;
    end
  end
endmodule : led_observer
`default_nettype wire

// ===== test/status_led_checker.sv
// Checker: indicator relations on the status_led_top ports.
// Assumes one clock domain and one cycle output latency.
`timescale 1ns/10ps
`default_nettype none
module status_led_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [2:0] sys_state_i,
  input wire logic power_good_i,
  input wire logic [3:0] fb_state_i,
  input wire logic sync_err_i,
  input wire logic [15:0] alarm_bits_i,
  input wire logic hw_fail_i,
  input wire logic system_green_o,
  input wire logic system_red_o,
  input wire logic run_led_o,
  input wire logic power_indicator_o,
  input wire logic alarm_indicator_o,
  input wire logic force_safeop_o,
  input wire logic [7:0] alarm_byte0_o,
  input wire logic [7:0] alarm_byte1_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [16:0] prev;
  wire logic ok = ce_i && power_good_i && !hw_fail_i;
  wire logic fb = ce_i && !sync_err_i && !force_safeop_o;
  always_ff @(posedge mclk_i) prev <= {power_good_i, alarm_bits_i};
  sequence s_sync_hit;
    ce_i && sync_err_i;
  endsequence
  sequence s_hw_held;
    (ce_i && hw_fail_i) [*2];
  endsequence
  a_green_running: assert property (ok && sys_state_i == 3'h4 |=> system_green_o && !system_red_o) else $error("green missing");
  a_red_boot: assert property (ok && sys_state_i == 3'h1 |=> system_red_o && !system_green_o) else $error("red missing");
  a_system_dark: assert property (ce_i && !power_good_i |=> !system_green_o && !system_red_o) else $error("system lit");
  a_run_op: assert property (fb && fb_state_i == 4'h8 |=> run_led_o) else $error("run off in op");
  a_run_init: assert property (fb && fb_state_i == 4'h1 |=> !run_led_o) else $error("run on in init");
  a_sync_forces: assert property (s_sync_hit |=> force_safeop_o) else $error("no safeop");
  a_alarm_hw: assert property (s_hw_held |-> alarm_indicator_o [*2]) else $error("alarm not steady");
  a_alarm_off: assert property (ce_i && !hw_fail_i && alarm_bits_i == 16'h0 |=> !alarm_indicator_o) else $error("alarm lit");
  a_alarm_word: assert property (ce_i |=> alarm_byte0_o == prev[7:0] && alarm_byte1_o == prev[15:8]) else $error("alarm word");
  a_power_follow: assert property (ce_i |=> power_indicator_o == prev[16]) else $error("power lag");
endmodule : status_led_checker
bind status_led_top status_led_checker chk_u (.*);
`default_nettype wire

// ===== test/fieldbus_status_led_driver_tb.sv
// Testbench for status_led_top: steady indicator states and fieldbus side.
// Assumes a 20 MHz clock; the run ends inside the first blink half period
// (blink low) and the first flash pulse (flash lit).
`timescale 1ns/10ps
`default_nettype none
module fieldbus_status_led_driver_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [2:0] sys_state_i = 3'h1;
  logic power_good_i = 1'b0;
  logic [3:0] fb_state_i = 4'h1;
  logic cfg_invalid_i = 1'b0;
  logic local_change_i = 1'b0;
  logic host_wdog_i = 1'b0;
  logic sync_err_i = 1'b0;
  logic app_wdog_i = 1'b0;
  logic err_clear_i = 1'b0;
  logic serial_act_i = 1'b0;
  logic [15:0] alarm_bits_i = 16'h0;
  logic hw_fail_i = 1'b0;
  logic system_green_o, system_red_o, err_led_o, run_led_o, serial_led_o;
  logic power_indicator_o, alarm_indicator_o, force_safeop_o;
  logic [7:0] alarm_byte0_o, alarm_byte1_o, err_edges;
  int miscompares = 0;
  int total_checks = 0;
  status_led_top dut_u (.*);
  led_observer obs_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .led_i(err_led_o),
    .edges_o(err_edges));
  always #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic settle;
    @(posedge mclk_i);
    #1;
  endtask : settle
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_system;
    @(posedge mclk_i);
    power_good_i <= 1'b1;
    sys_state_i <= 3'h4;
    settle();
    chk("green", {system_green_o, system_red_o}, 16'h2);
    @(posedge mclk_i);
    sys_state_i <= 3'h2;
    settle();
    chk("fw wait", {system_green_o, system_red_o}, 16'h1);
    @(posedge mclk_i);
    sys_state_i <= 3'h1;
    settle();
    chk("red", {system_green_o, system_red_o}, 16'h1);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    power_good_i <= 1'b0;
    settle();
    settle();
    chk("frozen", power_indicator_o, 16'h1);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    settle();
    chk("dark", {system_green_o, system_red_o, power_indicator_o}, 16'h0);
    @(posedge mclk_i);
    power_good_i <= 1'b1;
  endtask : t_system
  task automatic t_run_err;
    @(posedge mclk_i);
    fb_state_i <= 4'h8;
    settle();
    chk("run op", run_led_o, 16'h1);
    @(posedge mclk_i);
    fb_state_i <= 4'h4;
    settle();
    chk("run safeop", run_led_o, 16'h1);
    @(posedge mclk_i);
    fb_state_i <= 4'h2;
    settle();
    chk("run preop", run_led_o, 16'h0);
    @(posedge mclk_i);
    fb_state_i <= 4'h1;
    repeat (50) settle();
    chk("run init", run_led_o, 16'h0);
    chk("err dark", {err_led_o, err_edges}, 16'h0);
  endtask : t_run_err
  task automatic t_err;
    @(posedge mclk_i);
    local_change_i <= 1'b1;
    @(posedge mclk_i);
    local_change_i <= 1'b0;
    settle();
    chk("local err", err_led_o, 16'h1);
    @(posedge mclk_i);
    err_clear_i <= 1'b1;
    @(posedge mclk_i);
    err_clear_i <= 1'b0;
    settle();
    chk("err cleared", err_led_o, 16'h0);
    // Cause and clear together: the cause must win
    @(posedge mclk_i);
    host_wdog_i <= 1'b1;
    err_clear_i <= 1'b1;
    @(posedge mclk_i);
    host_wdog_i <= 1'b0;
    err_clear_i <= 1'b0;
    settle();
    chk("host wdog", err_led_o, 16'h1);
    @(posedge mclk_i);
    app_wdog_i <= 1'b1;
    cfg_invalid_i <= 1'b1;
    @(posedge mclk_i);
    app_wdog_i <= 1'b0;
    settle();
    chk("cfg first", err_led_o, 16'h0);
    @(posedge mclk_i);
    cfg_invalid_i <= 1'b0;
    settle();
    chk("double flash", err_led_o, 16'h1);
    @(posedge mclk_i);
    err_clear_i <= 1'b1;
    @(posedge mclk_i);
    err_clear_i <= 1'b0;
    settle();
    chk("err rises", {err_led_o, err_edges}, 16'h0003);
  endtask : t_err
  task automatic t_alarm;
    @(posedge mclk_i);
    alarm_bits_i <= 16'ha53c;
    settle();
    chk("alarm word", {alarm_byte1_o, alarm_byte0_o}, 16'ha53c);
    @(posedge mclk_i);
    hw_fail_i <= 1'b1;
    settle();
    settle();
    chk("hw fail", {alarm_indicator_o, system_green_o, system_red_o}, 16'h4);
    @(posedge mclk_i);
    alarm_bits_i <= 16'h0;
    hw_fail_i <= 1'b0;
    settle();
    chk("no alarm", alarm_indicator_o, 16'h0);
  endtask : t_alarm
  task automatic t_serial;
    settle();
    chk("serial idle", serial_led_o, 16'h0);
    @(posedge mclk_i);
    serial_act_i <= 1'b1;
    repeat (4) settle();
    chk("serial busy", serial_led_o, 16'h1);
    @(posedge mclk_i);
    serial_act_i <= 1'b0;
  endtask : t_serial
  task automatic t_sync;
    @(posedge mclk_i);
    sync_err_i <= 1'b1;
    @(posedge mclk_i);
    sync_err_i <= 1'b0;
    settle();
    chk("safeop held", {force_safeop_o, run_led_o, err_led_o}, 16'h7);
    @(posedge mclk_i);
    err_clear_i <= 1'b1;
    @(posedge mclk_i);
    err_clear_i <= 1'b0;
    settle();
    chk("safeop clear", {force_safeop_o, run_led_o, err_led_o}, 16'h0);
  endtask : t_sync
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (7) @(posedge mclk_i);
    #1;
    chk("reset", {system_green_o, system_red_o, force_safeop_o}, 16'h0);
    @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_system();
    t_run_err();
    t_err();
    t_alarm();
    t_serial();
    t_sync();
    print_verdict();
  end
  // Hang guard: the sequence needs well under this many cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    print_verdict();
  end
endmodule : fieldbus_status_led_driver_tb
`default_nettype wire
